// [common/mtc_pkg.sv]
package mtc_pkg;

  // ****************************************************************
  // Register map.
  // ****************************************************************
  localparam logic [3:0] MTC_CFG_ADDR = 4'h0;
  localparam logic [3:0] MTC_STAT_ADDR = 4'h4;

  // ****************************************************************
  // Configuration word field positions.
  // ****************************************************************
  localparam int MTC_B_RST = 31;
  localparam int MTC_B_JUMBO = 30;
  localparam int MTC_B_FCS = 29;
  localparam int MTC_B_EN = 28;
  localparam int MTC_B_VLAN = 27;
  localparam int MTC_B_WAN = 26;
  localparam int MTC_B_ADJ = 25;
  localparam int MTC_B_DIC = 24;
  localparam int MTC_B_PRE = 23;
  localparam int MTC_B_STACK = 21;
  localparam int MTC_B_RST_LANE = 3;

  // Status word field positions.
  localparam int MTC_S_CNT_W = 16;
  localparam int MTC_S_RST = 16;
  localparam int MTC_S_DIS = 17;

  // Reset value and writable bits of the configuration word.
  localparam logic [31:0] MTC_CFG_RESET = 32'h1000_0000;
  localparam logic [31:0] MTC_CFG_MASK = 32'h7FA0_0000;
  localparam logic [31:0] MTC_WAN_MASK = 32'h0400_0000;

  // ****************************************************************
  // Frame sizes, tag types and datapath widths.
  // ****************************************************************
  localparam logic [15:0] MTC_MAX_STD = 16'h05EE;
  localparam logic [15:0] MTC_MAX_VLAN = 16'h05F2;
  localparam logic [15:0] MTC_MAX_WAN_JUMBO = 16'h4000;
  localparam logic [15:0] MTC_TAG_STD = 16'h8100;
  localparam logic [15:0] MTC_TAG_STACK = 16'h88A8;
  localparam int MTC_DP_WAN = 64;

  // ****************************************************************
  // AXI responses.
  // ****************************************************************
  localparam logic [1:0] MTC_RESP_OKAY = 2'h0;
  localparam logic [1:0] MTC_RESP_SLVERR = 2'h2;

  // ****************************************************************
  // Timing: transmitter reset pulse.
  // ****************************************************************
  localparam int MTC_CLK_PS = 4000;
  localparam int MTC_TXRST_NS = 32;
  localparam int MTC_TXRST_CYC = (MTC_TXRST_NS * 1000 + MTC_CLK_PS - 1) / MTC_CLK_PS;
  localparam logic [3:0] MTC_TXRST_LAST = 4'(MTC_TXRST_CYC - 1);

  // Gap policy handed to the transmit path.
  typedef enum logic [1:0] {
    MTC_GAP_STRETCH,
    MTC_GAP_DIC,
    MTC_GAP_ADJ,
    MTC_GAP_WAN
  } mtc_gap_e;

endpackage : mtc_pkg

// [common/mtc_gap_if.sv]
`timescale 1ns/1ps
interface mtc_gap_if #(
  parameter int DLY_W = 8
);
  import mtc_pkg::*;
  logic tx_rst;
  logic wan_en;
  logic adj_en;
  logic dic_en;
  logic sof;
  logic [DLY_W-1:0] ifg_delay;
  mtc_gap_e gap_mode;
  logic [DLY_W-1:0] gap_delay;

  modport ctrl (output tx_rst, wan_en, adj_en, dic_en, sof, ifg_delay,
                input gap_mode, gap_delay);
  modport gap (input tx_rst, wan_en, adj_en, dic_en, sof, ifg_delay,
               output gap_mode, gap_delay);
endinterface : mtc_gap_if

// [verilog/mtc_gap_ctrl.sv]
`timescale 1ns/1ps
module mtc_gap_ctrl
  import mtc_pkg::*;
#(
  parameter int DLY_W = 8
) (
  input wire logic aclk,
  input wire logic aresetn,
  mtc_gap_if.gap g
);

  // ****************************************************************
  // Gap policy selection.
  // ****************************************************************
  // WAN pacing outranks the adjust port, which outranks deficit idle.
  mtc_gap_e mode_nxt;
  assign mode_nxt = g.wan_en ? MTC_GAP_WAN :
                    g.adj_en ? MTC_GAP_ADJ : // R12
                    g.dic_en ? MTC_GAP_DIC : MTC_GAP_STRETCH; // R13

  // The delay is sampled only at a frame start, so a change mid-frame
  // does not disturb the gap that follows the frame in flight.
  logic [DLY_W-1:0] dly_r;
  mtc_gap_e mode_r;
  always_ff @(posedge aclk) begin
    if (!aresetn || g.tx_rst) begin
      dly_r <= '0;
      mode_r <= MTC_GAP_STRETCH;
    end else if (g.sof) begin
      mode_r <= mode_nxt;
      dly_r <= (mode_nxt == MTC_GAP_ADJ) ? g.ifg_delay : '0; // R11
    end
  end

  assign g.gap_mode = mode_r;
  assign g.gap_delay = dly_r;

endmodule : mtc_gap_ctrl

// [verilog/mtc_top.sv]
// Contract
// R1: Writing one to bit 31 resets the transmitter; the bit self-clears.
// R2: That reset also returns the configuration word to its defaults.
// R3: Bit 30 permits frames above the legal maximum; clear limits to it.
// R4: Bit 29 set: client supplies FCS, transmitter forwards it unchanged.
// R5: Bit 29 clear: transmitter pads short frames and appends its own FCS.
// R6: Bit 28 enables the transmitter; it defaults to one.
// R7: Bit 27 allows VLAN frames, maximum 1522; clear keeps 1518.
// R8: Bit 26 inserts idles to match OC-192 payload rate; clear is LAN gaps.
// R9: In WAN mode client keeps jumbo frames at most 16384 bytes.
// R10: WAN mode exists only with a 64-bit datapath; else bit 26 reserved.
// R11: Bit 25 samples the gap-delay input at frame start to set the gap.
// R12: Gap adjust has no effect while WAN mode is set.
// R13: Bit 24 enables deficit idle count; clear stretches gaps for alignment.
// R14: Deficit idle count is forced clear while gap adjust is enabled.
// R15: Bit 23 sends the client preamble; clear sends the standard one.
// R16: Bit 21 handles up to 8 stacked tags, recognising 0x88A8 and 0x8100.
// R17: Reserved bits 22 and 20 to 0 read zero and ignore writes.
`timescale 1ns/1ps
module mtc_top
  import mtc_pkg::*;
#(
  parameter int DP_W = 64,
  parameter int DLY_W = 8,
  parameter logic [15:0] JUMBO_MAX = 16'hFFFF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_sof,
  input wire logic [DLY_W-1:0] tx_ifg_delay,
  output logic tx_reset,
  output logic tx_enable,
  output logic jumbo_en,
  output logic inband_fcs_en,
  output logic pad_fcs_en,
  output logic vlan_en,
  output logic [15:0] max_frame_len,
  output logic wan_en,
  output logic stack_vlan_en,
  output logic [15:0] vlan_tag_alt,
  output logic preserve_pre_en,
  output logic [1:0] gap_mode,
  output logic [DLY_W-1:0] gap_delay
);

  // ****************************************************************
  // Constants that depend on the build.
  // ****************************************************************
  // Bit 26 is writable only where the WAN pacer exists.
  localparam logic [31:0] WR_MASK =
    (DP_W == MTC_DP_WAN) ? MTC_CFG_MASK : (MTC_CFG_MASK & ~MTC_WAN_MASK); // R10 R17

  // ****************************************************************
  // Helper functions.
  // ****************************************************************
  // Expands byte strobes to a bit mask; used only by configuration writes.
  function automatic logic [31:0] lane_mask(input logic [3:0] strb);
    logic [31:0] m;
    m = '0;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = {8{strb[i]}};
    end
    return m;
  endfunction : lane_mask

  // Applies a masked, strobed write to a stored word.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] data,
                                        input logic [31:0] m);
    return (old & ~m) | (data & m);
  endfunction : merge

  // ****************************************************************
  // AXI4-Lite write channel.
  // ****************************************************************
  logic awready_r;
  logic wready_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic aw_hold_r;
  logic w_hold_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_take;
  logic w_take;
  logic do_wr;
  logic wr_cfg_hit;
  logic wr_stat_hit;

  assign aw_take = s_axi_awvalid && awready_r;
  assign w_take = s_axi_wvalid && wready_r;
  // Address and data may arrive in either order; both are held first.
  assign do_wr = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_cfg_hit = (awaddr_r == MTC_CFG_ADDR);
  assign wr_stat_hit = (awaddr_r == MTC_STAT_ADDR);

  // Address half of a write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      awready_r <= 1'b1;
      awaddr_r <= '0;
    end else if (aw_take) begin
      aw_hold_r <= 1'b1;
      awready_r <= 1'b0;
      awaddr_r <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_hold_r <= 1'b0;
      awready_r <= 1'b1;
    end
  end

  // Data half of a write.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_hold_r <= 1'b0;
      wready_r <= 1'b1;
      wdata_r <= '0;
      wstrb_r <= '0;
    end else if (w_take) begin
      w_hold_r <= 1'b1;
      wready_r <= 1'b0;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (do_wr) begin
      w_hold_r <= 1'b0;
      wready_r <= 1'b1;
    end
  end

  // Write response; a status word write clears its counters and answers OKAY.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= MTC_RESP_OKAY;
    end else if (do_wr) begin
      bvalid_r <= 1'b1;
      bresp_r <= (wr_cfg_hit || wr_stat_hit) ? MTC_RESP_OKAY : MTC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Configuration word.
  // ****************************************************************
  logic [31:0] cfg_r;
  logic [31:0] cfg_nxt;
  logic [31:0] wr_m;
  logic rst_req;
  logic cfg_we;

  assign cfg_we = do_wr && wr_cfg_hit;
  assign wr_m = lane_mask(wstrb_r);
  // A one in the reset bit wins over every other bit of the same write.
  assign rst_req = cfg_we && wstrb_r[MTC_B_RST_LANE] && wdata_r[MTC_B_RST]; // R1

  // Deficit idle is dropped whenever the stored adjust bit is set.
  always_comb begin
    cfg_nxt = merge(cfg_r, wdata_r, wr_m & WR_MASK); // R17
    if (cfg_nxt[MTC_B_ADJ]) begin
      cfg_nxt[MTC_B_DIC] = 1'b0; // R14
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || rst_req) begin
      cfg_r <= MTC_CFG_RESET; // R2 R6
    end else if (cfg_we) begin
      cfg_r <= cfg_nxt;
    end
  end

  // ****************************************************************
  // Transmitter reset pulse.
  // ****************************************************************
  // The pulse lasts long enough for the transmit path to flush; its
  // bit reads back as one only while the pulse runs, then reverts.
  logic txrst_r;
  logic [3:0] txrst_cnt_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      txrst_r <= 1'b0;
      txrst_cnt_r <= '0;
    end else if (rst_req) begin
      txrst_r <= 1'b1; // R1
      txrst_cnt_r <= '0;
    end else if (txrst_r) begin
      txrst_cnt_r <= txrst_cnt_r + 4'h1;
      if (txrst_cnt_r == MTC_TXRST_LAST) begin
        txrst_r <= 1'b0; // R1
      end
    end
  end

  // ****************************************************************
  // Effective controls for the transmit path.
  // ****************************************************************
  logic wan_eff;
  logic adj_eff;
  logic dic_eff;
  logic [15:0] max_len_nxt;

  assign wan_eff = (DP_W == MTC_DP_WAN) && cfg_r[MTC_B_WAN]; // R8 R10
  assign adj_eff = cfg_r[MTC_B_ADJ] && !wan_eff; // R12
  assign dic_eff = cfg_r[MTC_B_DIC] && !cfg_r[MTC_B_ADJ]; // R14
  // The WAN jumbo ceiling is advisory for the client; the limit still
  // guards the line so an oversized frame is cut rather than sent.
  assign max_len_nxt = !cfg_r[MTC_B_JUMBO] ?
                         (cfg_r[MTC_B_VLAN] ? MTC_MAX_VLAN : MTC_MAX_STD) : // R3 R7
                         (wan_eff ? MTC_MAX_WAN_JUMBO : JUMBO_MAX); // R9

  logic tx_enable_r;
  logic jumbo_r;
  logic fcs_r;
  logic pad_r;
  logic vlan_r;
  logic [15:0] max_len_r;
  logic wan_r;
  logic stack_r;
  logic [15:0] tag_alt_r;
  logic pre_r;

  // Registered so every control reaches the datapath from a flop.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_enable_r <= MTC_CFG_RESET[MTC_B_EN];
      jumbo_r <= 1'b0;
      fcs_r <= 1'b0;
      pad_r <= 1'b1;
      vlan_r <= 1'b0;
      max_len_r <= MTC_MAX_STD;
      wan_r <= 1'b0;
      stack_r <= 1'b0;
      tag_alt_r <= MTC_TAG_STD;
      pre_r <= 1'b0;
    end else begin
      // The request itself gates enable, so it drops with the reset pulse.
      tx_enable_r <= cfg_r[MTC_B_EN] && !txrst_r && !rst_req; // R6
      jumbo_r <= cfg_r[MTC_B_JUMBO]; // R3
      fcs_r <= cfg_r[MTC_B_FCS]; // R4
      pad_r <= !cfg_r[MTC_B_FCS]; // R5
      vlan_r <= cfg_r[MTC_B_VLAN]; // R7
      max_len_r <= max_len_nxt; // R3 R7
      wan_r <= wan_eff; // R8
      stack_r <= cfg_r[MTC_B_STACK]; // R16
      tag_alt_r <= cfg_r[MTC_B_STACK] ? MTC_TAG_STACK : MTC_TAG_STD; // R16
      pre_r <= cfg_r[MTC_B_PRE]; // R15
    end
  end

  // ****************************************************************
  // Gap control and frame statistics.
  // ****************************************************************
  mtc_gap_if #(.DLY_W(DLY_W)) gif ();

  assign gif.tx_rst = txrst_r;
  assign gif.wan_en = wan_eff;
  assign gif.adj_en = adj_eff;
  assign gif.dic_en = dic_eff;
  assign gif.sof = tx_sof && tx_enable_r;
  assign gif.ifg_delay = tx_ifg_delay;

  mtc_gap_ctrl #(.DLY_W(DLY_W)) u_gap (
    .aclk(aclk),
    .aresetn(aresetn),
    .g(gif.gap)
  );

  // Counts frame starts accepted; refused starts raise a sticky flag.
  logic [MTC_S_CNT_W-1:0] sof_cnt_r;
  logic dis_seen_r;
  logic stat_clr;

  assign stat_clr = do_wr && wr_stat_hit;

  always_ff @(posedge aclk) begin
    if (!aresetn || txrst_r) begin
      sof_cnt_r <= '0;
      dis_seen_r <= 1'b0;
    end else begin
      if (gif.sof) begin
        sof_cnt_r <= sof_cnt_r + 1'b1;
      end else if (stat_clr) begin
        sof_cnt_r <= '0;
      end
      // A refused frame in the clear cycle still sets the flag.
      if (tx_sof && !tx_enable_r) begin
        dis_seen_r <= 1'b1; // R6
      end else if (stat_clr) begin
        dis_seen_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // AXI4-Lite read channel.
  // ****************************************************************
  logic arready_r;
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic ar_take;
  logic rd_cfg_hit;
  logic rd_stat_hit;
  logic [31:0] cfg_rd;
  logic [31:0] stat_rd;

  assign ar_take = s_axi_arvalid && arready_r;
  assign rd_cfg_hit = (s_axi_araddr == MTC_CFG_ADDR);
  assign rd_stat_hit = (s_axi_araddr == MTC_STAT_ADDR);
  // Reserved bits read as zero; the reset bit shows the live pulse.
  assign cfg_rd = (cfg_r & WR_MASK) | ({31'h0, txrst_r} << MTC_B_RST); // R1 R17
  assign stat_rd = {14'h0, dis_seen_r, txrst_r, sof_cnt_r};

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_r <= 1'b1;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= MTC_RESP_OKAY;
    end else if (ar_take) begin
      arready_r <= 1'b0;
      rvalid_r <= 1'b1;
      if (rd_cfg_hit) begin
        rdata_r <= cfg_rd;
        rresp_r <= MTC_RESP_OKAY;
      end else if (rd_stat_hit) begin
        rdata_r <= stat_rd;
        rresp_r <= MTC_RESP_OKAY;
      end else begin
        rdata_r <= '0;
        rresp_r <= MTC_RESP_SLVERR;
      end
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
      arready_r <= 1'b1;
    end
  end

  // ****************************************************************
  // Outputs.
  // ****************************************************************
  assign s_axi_awready = awready_r;
  assign s_axi_wready = wready_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = arready_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign tx_reset = txrst_r;
  assign tx_enable = tx_enable_r;
  assign jumbo_en = jumbo_r;
  assign inband_fcs_en = fcs_r;
  assign pad_fcs_en = pad_r;
  assign vlan_en = vlan_r;
  assign max_frame_len = max_len_r;
  assign wan_en = wan_r;
  assign stack_vlan_en = stack_r;
  assign vlan_tag_alt = tag_alt_r;
  assign preserve_pre_en = pre_r;
  assign gap_mode = gif.gap_mode;
  assign gap_delay = gif.gap_delay;

endmodule : mtc_top

// [verification/mtc_chk.sv]
`timescale 1ns/1ps
module mtc_chk
  import mtc_pkg::*;
#(
  parameter int DLY_W = 8,
  parameter logic [15:0] JUMBO_MAX = 16'hFFFF
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_sof,
  input wire logic [DLY_W-1:0] tx_ifg_delay,
  input wire logic tx_reset,
  input wire logic tx_enable,
  input wire logic jumbo_en,
  input wire logic inband_fcs_en,
  input wire logic pad_fcs_en,
  input wire logic vlan_en,
  input wire logic [15:0] max_frame_len,
  input wire logic wan_en,
  input wire logic stack_vlan_en,
  input wire logic [15:0] vlan_tag_alt,
  input wire logic [1:0] gap_mode,
  input wire logic [DLY_W-1:0] gap_delay
);
  // ****
  // Checks on the configuration outputs and the register bus.
  // ****
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  rst_dflt_a: assert property ($rose(aresetn) |-> tx_enable && pad_fcs_en && !tx_reset)
    else $error("outputs not at defaults after reset");
  txrst_len_a: assert property ($rose(tx_reset) |-> tx_reset [*8] ##1 !tx_reset)
    else $error("transmitter reset pulse has the wrong length");
  txrst_dis_a: assert property (tx_reset |-> !tx_enable)
    else $error("transmitter enabled during its reset");
  fcs_pair_a: assert property (pad_fcs_en != inband_fcs_en)
    else $error("padding and in-band FCS not exclusive");
  len_std_a: assert property (!jumbo_en |-> max_frame_len == (vlan_en ? 16'h05F2 : 16'h05EE))
    else $error("standard maximum length wrong");
  len_jmb_a: assert property (jumbo_en |-> max_frame_len == (wan_en ? 16'h4000 : JUMBO_MAX))
    else $error("jumbo maximum length wrong");
  tag_sel_a: assert property (vlan_tag_alt == (stack_vlan_en ? 16'h88A8 : 16'h8100))
    else $error("alternate tag type wrong");
  gap_hold_a: assert property (!(tx_sof && tx_enable) && !tx_reset |=> $stable(gap_mode))
    else $error("gap policy moved without a frame start");
  gap_wan_a: assert property (tx_sof && tx_enable && wan_en |=> gap_mode == 2'h3)
    else $error("wide area gap not chosen");
  gap_dly_a: assert property (tx_sof && tx_enable ##1 gap_mode == 2'h2
    |-> gap_delay == $past(tx_ifg_delay))
    else $error("gap delay not taken at frame start");
  rd_ans_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped before taken");

  rst_c: cover property ($rose(tx_reset));
  wan_c: cover property (tx_sof && tx_enable && wan_en);
  adj_c: cover property (gap_mode == 2'h2 && gap_delay != '0);
  err_c: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule : mtc_chk

// [verification/mtc_client_model.sv]
`timescale 1ns/1ps
module mtc_client_model #(
  parameter int DLY_W = 8
) (
  input wire logic aclk,
  output logic tx_sof,
  output logic [DLY_W-1:0] tx_ifg_delay
);
  // ****
  // Client frame starts.
  // ****
  // Quiet until the first frame.
  initial begin
    tx_sof = 1'b0;
    tx_ifg_delay = '0;
  end

  // The delay is valid only with the start pulse, so it is scrambled after.
  task automatic send_frame(input logic [DLY_W-1:0] dly, input int idle);
    repeat (idle) @(posedge aclk);
    tx_sof <= 1'b1;
    tx_ifg_delay <= dly;
    @(posedge aclk);
    tx_sof <= 1'b0;
    tx_ifg_delay <= ~dly;
  endtask : send_frame
endmodule : mtc_client_model

// [verification/mtc_tb_top.sv]
`timescale 1ns/1ps
module mtc_tb_top
  import mtc_pkg::*;
;
  localparam logic [15:0] JMAX = 16'hFFFF;
  logic aclk, aresetn, tx_sof, tx_reset, tx_enable, jumbo_en, inband_fcs_en, pad_fcs_en;
  logic vlan_en, wan_en, stack_vlan_en, preserve_pre_en, dis_e;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr, ws;
  logic [31:0] s_axi_wdata, s_axi_rdata, cfg_e, rd_d, wd;
  logic [1:0] s_axi_bresp, s_axi_rresp, gap_mode, gap_e, resp;
  logic [15:0] max_frame_len, vlan_tag_alt;
  logic [7:0] tx_ifg_delay, gap_delay, dly_e;
  logic [31:0] corner [5];
  int n_fail, n_tests, rst_cyc, cnt_e;
  integer seed;

  mtc_top #(.DP_W(64), .DLY_W(8), .JUMBO_MAX(JMAX)) u_mtc_top (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .tx_sof,
    .tx_ifg_delay, .tx_reset, .tx_enable, .jumbo_en, .inband_fcs_en, .pad_fcs_en, .vlan_en,
    .max_frame_len, .wan_en, .stack_vlan_en, .vlan_tag_alt, .preserve_pre_en, .gap_mode,
    .gap_delay);
  mtc_client_model #(.DLY_W(8)) u_mtc_client_model (.aclk, .tx_sof, .tx_ifg_delay);

  // ****
  // Clock, pulse counter and watchdog.
  // ****
  initial aclk = 1'b0;
  always #2 aclk = ~aclk;
  // Counts transmitter reset cycles so the pulse length is judged whole.
  always @(posedge aclk) if (tx_reset === 1'b1) rst_cyc <= rst_cyc + 1;
  // A hang ends the run with a mismatch; the full run needs about 600 cycles.
  initial begin
    repeat (20000) @(posedge aclk);
    n_fail++;
    final_report;
  end

  // ****
  // Bench tasks.
  // ****
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : final_report

  // Address and data are offered together; each is dropped once taken.
  task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
                    output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 100);
    if (n >= 100) n_fail++;
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  // Read ready comes at a random moment to exercise a held answer.
  task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (!s_axi_rready) s_axi_rready <= 1'($random(seed) & 1);
    end while (!(s_axi_rvalid && s_axi_rready) && n < 100);
    if (n >= 100) n_fail++;
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  function automatic logic [31:0] merge(input logic [31:0] o, d, input logic [3:0] s);
    logic [31:0] m;
    m = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
    merge = (o & ~m | d & m) & 32'h7FA0_0000;
    if (merge[25]) merge[24] = 1'b0;
  endfunction : merge

  task automatic check_outs;
    logic [15:0] len;
    len = cfg_e[30] ? (cfg_e[26] ? 16'h4000 : JMAX) : (cfg_e[27] ? 16'h05F2 : 16'h05EE);
    chk("tx_enable", tx_enable, cfg_e[28]);
    chk("jumbo_en", jumbo_en, cfg_e[30]);
    chk("inband_fcs_en", inband_fcs_en, cfg_e[29]);
    chk("pad_fcs_en", pad_fcs_en, !cfg_e[29]);
    chk("vlan_en", vlan_en, cfg_e[27]);
    chk("wan_en", wan_en, cfg_e[26]);
    chk("preserve_pre_en", preserve_pre_en, cfg_e[23]);
    chk("stack_vlan_en", stack_vlan_en, cfg_e[21]);
    chk("max_frame_len", max_frame_len, len);
    chk("vlan_tag_alt", vlan_tag_alt, cfg_e[21] ? 16'h88A8 : 16'h8100);
    rd(MTC_CFG_ADDR, rd_d, resp);
    chk("cfg", rd_d, cfg_e);
    chk("cfg resp", resp, 2'h0);
  endtask : check_outs

  // One frame start; a disabled transmitter must ignore it.
  task automatic frame;
    logic [7:0] d;
    d = 8'($random(seed));
    u_mtc_client_model.send_frame(d, 1 + ($random(seed) & 3));
    if (cfg_e[28]) begin
      cnt_e++;
      gap_e = cfg_e[26] ? 2'h3 : cfg_e[25] ? 2'h2 : cfg_e[24] ? 2'h1 : 2'h0;
      dly_e = (cfg_e[25] && !cfg_e[26]) ? d : 8'h00;
    end else dis_e = 1'b1;
    repeat (2) @(posedge aclk);
    chk("gap_mode", gap_mode, gap_e);
    chk("gap_delay", gap_delay, dly_e);
  endtask : frame

  // ****
  // Main sequence.
  // ****
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_wstrb, s_axi_araddr, s_axi_wdata} = '0;
    n_fail = 0;
    n_tests = 0;
    rst_cyc = 0;
    seed = 2954;
    aresetn = 1'b0;
    corner = '{32'h0700_0000, 32'h0300_0000, 32'h5100_0000, 32'h7FFF_FFFF, 32'h4C00_0000};
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    cfg_e = 32'h1000_0000;
    {gap_e, dly_e, dis_e, cnt_e} = '0;
    check_outs;
    wr(MTC_STAT_ADDR, 32'h0, 4'hF, resp);
    for (int i = 0; i < 30; i++) begin
      wd = i < 5 ? corner[i] : $random(seed);
      ws = i < 5 ? 4'hF : 4'($random(seed));
      wd[31] = 1'b0;
      wr(MTC_CFG_ADDR, wd, ws, resp);
      chk("wr resp", resp, 2'h0);
      cfg_e = merge(cfg_e, wd, ws);
      repeat (2) @(posedge aclk);
      check_outs;
      frame;
    end
    rd(MTC_STAT_ADDR, rd_d, resp);
    chk("sof count", rd_d[15:0], cnt_e[15:0]);
    chk("disabled sof", rd_d[17], dis_e);
    wr(4'h8, 32'hFFFF_FFFF, 4'hF, resp);
    chk("bad wr resp", resp, 2'h2);
    rd(4'h8, rd_d, resp);
    chk("bad rd resp", resp, 2'h2);
    chk("bad rd data", rd_d, 32'h0);
    rst_cyc = 0;
    wr(MTC_CFG_ADDR, 32'hFFFF_FFFF, 4'hF, resp);
    chk("tx_enable in reset", tx_enable, 32'h0);
    repeat (20) @(posedge aclk);
    chk("reset cycles", rst_cyc, 8);
    cfg_e = 32'h1000_0000;
    check_outs;
    rd(MTC_STAT_ADDR, rd_d, resp);
    chk("cleared count", rd_d, 32'h0);
    frame;
    final_report;
  end
endmodule : mtc_tb_top

bind mtc_top mtc_chk #(.DLY_W(DLY_W), .JUMBO_MAX(JUMBO_MAX)) u_mtc_chk (.aclk, .aresetn,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
  .tx_sof, .tx_ifg_delay, .tx_reset, .tx_enable, .jumbo_en, .inband_fcs_en, .pad_fcs_en,
  .vlan_en, .max_frame_len, .wan_en, .stack_vlan_en, .vlan_tag_alt, .gap_mode, .gap_delay);
